//--- wdt_core.sv
/*
 Watchdog unit: protected control registers on an Avalon-MM slave, a
 10-bit overflow counter, and overflow delivery as reset or NMI request.
 Assumes oscillator strobes are synchronous to clk_i, protection state comes
 from the protection key register held here, and halt/sleep need no gating.
*/
`timescale 1ns/1ps
module wdt_core
	import wdt_pkg::*;
#(
	parameter logic [3:0] SOURCE_PRESENT = 4'hf
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        debug_mode_i,
	input  wire logic        internal_osc_i,
	input  wire logic        low_speed_osc_i,
	input  wire logic        high_speed_osc_i,
	input  wire logic        external_clk_i,
	output logic             system_reset_req_o,
	output logic             nmi_req_o,
	output logic             unlocked_o
);

	wdt_tick_if tk ();

	// Register state
	logic        debug_run_reg,   debug_run_next;
	logic [1:0]  div_reg,         div_next;
	logic [1:0]  src_reg,         src_next;
	logic        action_reg,      action_next;
	logic        status_reg,      status_next;
	logic [3:0]  run_reg,         run_next;
	logic        unlocked_reg,    unlocked_next;
	count_t      count_reg,       count_next;
	logic        rst_req_reg,     rst_req_next;
	logic        nmi_req_reg,     nmi_req_next;
	logic [31:0] rdata_reg,       rdata_next;
	logic        ack_reg,         ack_next;

	// Decoded bus strobes
	logic        req;
	logic        wr_ctl;
	logic        wr_clk;
	logic        wr_key;
	logic        clear_cmd;
	logic        running;
	logic        overflow;
	logic [15:0] wlow;
	logic [3:0]  run_view;

	////////////////////////////////////////////////////////////////////////
	// Tick generator
	assign tk.src_sel   = src_reg;
	assign tk.div_sel   = div_reg;
	assign tk.gate_open = !debug_mode_i || debug_run_reg;

	wdt_tick_gen i_wdt_tick_gen
	(
		.clk_i            (clk_i),
		.rst_n_i          (rst_n_i),
		.internal_osc_i   (internal_osc_i),
		.low_speed_osc_i  (low_speed_osc_i),
		.high_speed_osc_i (high_speed_osc_i),
		.external_clk_i   (external_clk_i),
		.tk               (tk.selector)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode; one wait state so every access answers on its second edge
	always_comb
	begin
		req       = (avs_read_i || avs_write_i) && !ack_reg;
		wlow      = avs_writedata_i[15:0];
		wr_ctl    = req && avs_write_i && (avs_address_i == OFS_CONTROL)
		            && unlocked_reg && avs_byteenable_i[0] && avs_byteenable_i[1];
		wr_clk    = req && avs_write_i && (avs_address_i == OFS_CLOCK_CONTROL)
		            && unlocked_reg && avs_byteenable_i[0] && avs_byteenable_i[1];
		wr_key    = req && avs_write_i && (avs_address_i == OFS_PROTECT_KEY)
		            && avs_byteenable_i[0] && avs_byteenable_i[1];
		clear_cmd = wr_ctl && wlow[POS_CLEAR]; // Zero written here is ignored
		running   = (run_reg != RUN_STOP_CODE);
		overflow  = running && tk.tick && (count_reg == '1);
		run_view  = running ? RUN_READ_RUNNING : RUN_STOP_CODE;
	end

	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;

	////////////////////////////////////////////////////////////////////////
	// Register next-state
	always_comb
	begin
		debug_run_next = debug_run_reg;
		div_next       = div_reg;
		src_next       = src_reg;
		action_next    = action_reg;
		run_next       = run_reg;
		unlocked_next  = unlocked_reg;
		if (wr_key)
		begin
			unlocked_next = (wlow == UNLOCK_KEY); // Any other value relocks
		end
		if (wr_clk)
		begin
			debug_run_next = wlow[POS_DEBUG_RUN];
			div_next       = wlow[POS_DIV_LO +: 2];
			// Only implemented sources are accepted
			if (SOURCE_PRESENT[wlow[POS_SRC_LO +: 2]])
			begin
				src_next = wlow[POS_SRC_LO +: 2];
			end
		end
		if (wr_ctl)
		begin
			action_next = wlow[POS_ACTION];
			run_next    = wlow[POS_RUN_LO +: 4];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter, status flag and overflow requests
	always_comb
	begin
		count_next   = count_reg;
		status_next  = status_reg;
		rst_req_next = 1'b0;
		nmi_req_next = 1'b0;
		// Counts every tick while the run field is not the stop code; halt and sleep do not gate it
		if (running && tk.tick)
		begin
			count_next = count_reg + 1'b1; // Wraps to zero after overflow
		end
		if (overflow)
		begin
			if (action_reg)
			begin
				nmi_req_next = 1'b1;
				status_next  = 1'b1;
			end
			else
			begin
				rst_req_next = 1'b1;
			end
		end
		// Clear wins over a same-cycle tick: new full period starts
		if (clear_cmd)
		begin
			count_next = '0;
			// An NMI-mode overflow in the same cycle keeps the flag set
			status_next = overflow && action_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data mux
	always_comb
	begin
		rdata_next = rdata_reg;
		ack_next   = req;
		if (req && avs_read_i)
		begin
			unique case (avs_address_i)
				OFS_CLOCK_CONTROL:
					rdata_next = {23'h00_0000, debug_run_reg, 2'h0, div_reg, 2'h0, src_reg};
				OFS_CONTROL: // Clear bit always reads zero
					rdata_next = {22'h00_0000, action_reg, status_reg, 4'h0, run_view};
				OFS_PROTECT_KEY:
					rdata_next = {31'h0000_0000, unlocked_reg};
				default:
					rdata_next = 32'h0000_0000; // Unmapped reads zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			debug_run_reg <= 1'b0;
			div_reg       <= DIV_RESET;
			src_reg       <= SRC_RESET;
			action_reg    <= 1'b0;
			status_reg    <= 1'b0;
			run_reg       <= RUN_STOP_CODE; // Comes out of reset stopped
			unlocked_reg  <= 1'b0;
			count_reg     <= '0;
			rst_req_reg   <= 1'b0;
			nmi_req_reg   <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
			ack_reg       <= 1'b0;
		end
		else
		begin
			debug_run_reg <= debug_run_next;
			div_reg       <= div_next;
			src_reg       <= src_next;
			action_reg    <= action_next;
			status_reg    <= status_next;
			run_reg       <= run_next;
			unlocked_reg  <= unlocked_next;
			count_reg     <= count_next;
			rst_req_reg   <= rst_req_next;
			nmi_req_reg   <= nmi_req_next;
			rdata_reg     <= rdata_next;
			ack_reg       <= ack_next;
		end
	end

	// Outputs
	assign avs_readdata_o     = rdata_reg;
	assign system_reset_req_o = rst_req_reg;
	assign nmi_req_o          = nmi_req_reg;
	assign unlocked_o         = unlocked_reg;

endmodule

//--- wdt_pkg.sv
/*
 Constants and types shared by the watchdog unit: register offsets, field
 positions, reset values, key codes and divider ratios.
 Assumes a 32-bit Avalon-MM register bus with word-aligned registers.
*/
package wdt_pkg;

	// Byte offsets of the registers
	localparam logic [3:0]  OFS_CLOCK_CONTROL = 4'h0;
	localparam logic [3:0]  OFS_CONTROL       = 4'h4;
	localparam logic [3:0]  OFS_PROTECT_KEY   = 4'h8;

	// Clock control fields
	localparam int          POS_DEBUG_RUN     = 8;
	localparam int          POS_DIV_LO        = 4;
	localparam int          POS_SRC_LO        = 0;

	// Control fields
	localparam int          POS_ACTION        = 9;
	localparam int          POS_STATUS        = 8;
	localparam int          POS_CLEAR         = 4;
	localparam int          POS_RUN_LO        = 0;

	// Key codes and reset values
	localparam logic [15:0] UNLOCK_KEY        = 16'h0096;
	localparam logic [3:0]  RUN_STOP_CODE     = 4'ha;
	localparam logic [3:0]  RUN_READ_RUNNING  = 4'h0;
	localparam logic [1:0]  DIV_RESET         = 2'h0;
	localparam logic [1:0]  SRC_RESET         = 2'h0;

	// Clock source codes
	localparam logic [1:0]  SRC_INTERNAL      = 2'h0;
	localparam logic [1:0]  SRC_LOW_SPEED     = 2'h1;
	localparam logic [1:0]  SRC_HIGH_SPEED    = 2'h2;
	localparam logic [1:0]  SRC_EXTERNAL      = 2'h3;

	// Prescaler widths: 2048..16384 and 128
	localparam int          PRESCALE_W        = 14;
	localparam int          DIV_BASE_LOG2     = 11;
	localparam int          LOW_SPEED_LOG2    = 7;

	// Counter width: overflow after 1024 ticks
	localparam int          COUNT_W           = 10;

	typedef logic [COUNT_W-1:0] count_t;

endpackage

//--- wdt_tick_if.sv
/*
 Interface carrying the counter clock selection and the resulting tick from
 the source selector to the watchdog core.
 Assumes one clock domain; the tick is a single-cycle enable.
*/
`timescale 1ns/1ps
interface wdt_tick_if;
	logic [1:0] src_sel;
	logic [1:0] div_sel;
	logic       gate_open;
	logic       tick;

	modport selector
	(
		input  src_sel,
		input  div_sel,
		input  gate_open,
		output tick
	);

	modport core
	(
		output src_sel,
		output div_sel,
		output gate_open,
		input  tick
	);
endinterface

//--- wdt_tick_gen.sv
/*
 Counter clock generator: detects rising edges of the chosen oscillator
 strobe and divides them into one-cycle ticks for the watchdog counter.
 Assumes the oscillator inputs are slow levels synchronous to clk_i.
*/
`timescale 1ns/1ps
module wdt_tick_gen
	import wdt_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic internal_osc_i,
	input  wire logic low_speed_osc_i,
	input  wire logic high_speed_osc_i,
	input  wire logic external_clk_i,
	wdt_tick_if.selector tk
);

	logic                  osc_sel;
	logic                  osc_prev_reg;
	logic                  osc_prev_next;
	logic                  edge_seen;
	logic [PRESCALE_W-1:0] pre_reg;
	logic [PRESCALE_W-1:0] pre_next;
	logic [PRESCALE_W-1:0] pre_mask;

	////////////////////////////////////////////////////////////////////////
	// Source mux and division mask
	always_comb
	begin
		osc_sel  = internal_osc_i;
		pre_mask = '0;
		unique case (tk.src_sel)
			SRC_INTERNAL:
			begin
				osc_sel  = internal_osc_i;
				pre_mask = PRESCALE_W'((1 << (DIV_BASE_LOG2 + int'(tk.div_sel))) - 1);
			end
			SRC_LOW_SPEED:
			begin
				osc_sel  = low_speed_osc_i;
				pre_mask = PRESCALE_W'((1 << LOW_SPEED_LOG2) - 1);
			end
			SRC_HIGH_SPEED:
			begin
				osc_sel  = high_speed_osc_i;
				pre_mask = PRESCALE_W'((1 << (DIV_BASE_LOG2 + int'(tk.div_sel))) - 1);
			end
			SRC_EXTERNAL:
			begin
				osc_sel  = external_clk_i;
				pre_mask = '0; // Divide by one
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Edge detect and prescaler; a stopped source produces no edges
	always_comb
	begin
		osc_prev_next = osc_sel;
		edge_seen     = osc_sel & ~osc_prev_reg;
		pre_next      = pre_reg;
		tk.tick       = 1'b0;
		if (edge_seen && tk.gate_open) // Debug gate withholds the clock
		begin
			if ((pre_reg & pre_mask) == pre_mask)
			begin
				pre_next = '0;
				tk.tick  = 1'b1;
			end
			else
			begin
				pre_next = pre_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			osc_prev_reg <= 1'b0;
			pre_reg      <= '0;
		end
		else
		begin
			osc_prev_reg <= osc_prev_next;
			pre_reg      <= pre_next;
		end
	end

endmodule

//--- wdt_osc_model.sv
/*
 Oscillator model: four source levels synchronous to clk_i.
 Assumes the bench gates each source through en_i.
*/
`timescale 1ns/1ps
module wdt_osc_model
(
	input  wire logic       clk_i,
	input  wire logic [3:0] en_i,
	output logic      [3:0] osc_o
);
	// A stopped source holds its level, as a halted oscillator does
	initial osc_o = 4'h0;
	always @(posedge clk_i)
	begin
		osc_o <= osc_o ^ en_i;
	end
endmodule

//--- wdt_checker.sv
/*
 Port assertions for the watchdog: handshake, key register, requests.
 Assumes it is bound to wdt_core.
*/
`timescale 1ns/1ps
module wdt_checker
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [3:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        system_reset_req_o,
	input wire logic        nmi_req_o,
	input wire logic        unlocked_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Key write taken on its first cycle
	wire key_wr = avs_write_i && avs_waitrequest_o && avs_address_i == 4'h8
		&& avs_byteenable_i[1:0] == 2'b11;
	wire ctl_rd = avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h4;
	////////////////////////////////////////////////////////////////////////////
	a_nmi_single: assert property (nmi_req_o |=> !nmi_req_o)
		else $error("nmi request too long");
	a_reset_single: assert property (system_reset_req_o |=> !system_reset_req_o)
		else $error("reset request too long");
	a_one_action: assert property (!(nmi_req_o && system_reset_req_o))
		else $error("both requests at once");
	a_wait_second: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("late answer");
	a_key_unlock: assert property (key_wr && avs_writedata_i[15:0] == 16'h0096 |=> unlocked_o)
		else $error("key did not unlock");
	a_key_lock: assert property (key_wr && avs_writedata_i[15:0] != 16'h0096 |=> !unlocked_o)
		else $error("other value did not lock");
	a_lock_cause: assert property (!$stable(unlocked_o) |-> $past(key_wr))
		else $error("lock changed without key write");
	a_ctl_read: assert property (ctl_rd |-> avs_readdata_o[4] == 1'b0
		&& (avs_readdata_o[3:0] == 4'ha || avs_readdata_o[3:0] == 4'h0))
		else $error("control readback wrong");
	// Main scenarios reached
	c_nmi: cover property (nmi_req_o);
	c_reset: cover property (system_reset_req_o);
	c_unlock: cover property (key_wr);
endmodule

bind wdt_core wdt_checker i_wdt_checker (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
	.avs_waitrequest_o, .system_reset_req_o, .nmi_req_o, .unlocked_o);

//--- wdt_core_bench.sv
/*
 Self-checking watchdog bench: registers, timeouts, debug freeze, stop.
 Assumes the external source toggles every cycle: one tick per two cycles.
*/
`timescale 1ns/1ps
module wdt_core_bench
	import wdt_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [3:0]  avs_address_i = 4'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        debug_mode_i = 1'b0;
	logic [3:0]  osc_en = 4'hf;
	logic [3:0]  osc;
	logic        system_reset_req_o;
	logic        nmi_req_o;
	logic        unlocked_o;
	logic [31:0] q;
	int          mismatches = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          nmi_cnt = 0;
	int          rst_cnt = 0;
	int          n;

	wdt_osc_model i_wdt_osc_model (.clk_i, .en_i(osc_en), .osc_o(osc));
	// High-speed source left out to exercise the refusal of absent sources
	wdt_core #(.SOURCE_PRESENT(4'hb)) i_wdt_core (.clk_i, .rst_n_i, .avs_address_i,
		.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
		.avs_readdata_o, .avs_waitrequest_o, .debug_mode_i, .internal_osc_i(osc[0]),
		.low_speed_osc_i(osc[1]), .high_speed_osc_i(osc[2]), .external_clk_i(osc[3]),
		.system_reset_req_o, .nmi_req_o, .unlocked_o);

	always #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////////
	// Request counters and the hang limit
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		nmi_cnt <= nmi_cnt + int'(nmi_req_o === 1'b1);
		rst_cnt <= rst_cnt + int'(system_reset_req_o === 1'b1);
		if (cycles == 40000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge; data taken there
	task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
		avs_address_i <= a;
		avs_writedata_i <= {16'h0000, d};
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do
			@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 16'h0000);
		check(what, q, exp);
	endtask

	// Cycles until the next request, capped at limit
	task automatic wait_event(input int limit);
		int c;
		c = nmi_cnt + rst_cnt;
		n = 0;
		while (nmi_cnt + rst_cnt == c && n < limit)
		begin
			@(posedge clk_i);
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rd(OFS_CLOCK_CONTROL, 32'h0000_0000, "clock reset");
		wr(OFS_CONTROL, 16'h0215);
		rd(OFS_CONTROL, 32'h0000_000a, "locked control");
		wr(OFS_PROTECT_KEY, UNLOCK_KEY);
		rd(OFS_PROTECT_KEY, 32'h0000_0001, "key");
		check("unlocked pin", 32'(unlocked_o), 32'h0000_0001);
		// Both low lanes are needed; a partial write is dropped
		avs_byteenable_i <= 4'h1;
		wr(OFS_CONTROL, 16'h0215);
		avs_byteenable_i <= 4'hf;
		rd(OFS_CONTROL, 32'h0000_000a, "partial lanes");
		rd(4'hc, 32'h0000_0000, "unmapped");
		for (int k = 0; k < 4; k++)
		begin
			wr(OFS_CLOCK_CONTROL, 16'(k << 4));
			rd(OFS_CLOCK_CONTROL, 32'(k << 4), "divider");
		end
		// NMI mode on the external source, debug with debug-run set
		// Fast source keeps runs short; real software aims near 256 Hz
		wr(OFS_CLOCK_CONTROL, 16'h0103);
		wr(OFS_CONTROL, 16'h0215);
		wr(OFS_PROTECT_KEY, 16'h0000);
		check("relocked pin", 32'(unlocked_o), 32'h0000_0000);
		rd(OFS_CONTROL, 32'h0000_0200, "running");
		debug_mode_i <= 1'b1;
		wait_event(3000);
		debug_mode_i <= 1'b0;
		check("nmi period", 32'(n inside {[2020:2060]}), 32'h0000_0001);
		check("nmi count", 32'(nmi_cnt), 32'h0000_0001);
		rd(OFS_CONTROL, 32'h0000_0300, "status");
		// A clear mid-period restarts a full period
		wr(OFS_PROTECT_KEY, UNLOCK_KEY);
		wr(OFS_CONTROL, 16'h0215);
		rd(OFS_CONTROL, 32'h0000_0200, "status cleared");
		repeat (1500) @(posedge clk_i);
		wr(OFS_CONTROL, 16'h0215);
		wait_event(3000);
		check("restart", 32'(n inside {[2020:2060]}), 32'h0000_0001);
		// Debug freeze without debug-run
		wr(OFS_CLOCK_CONTROL, 16'h0003);
		wr(OFS_CONTROL, 16'h0215);
		debug_mode_i <= 1'b1;
		wait_event(2500);
		check("debug freeze", 32'(n), 32'h0000_09c4);
		debug_mode_i <= 1'b0;
		wait_event(3000);
		check("debug resume", 32'(n inside {[2020:2060]}), 32'h0000_0001);
		// Reset mode
		wr(OFS_CONTROL, 16'h0015);
		wait_event(3000);
		check("reset count", 32'(rst_cnt), 32'h0000_0001);
		rd(OFS_CONTROL, 32'h0000_0000, "no status in reset mode");
		check("nmi total", 32'(nmi_cnt), 32'h0000_0003);
		// Stop code, then a stopped source
		wr(OFS_CONTROL, 16'h001a);
		rd(OFS_CONTROL, 32'h0000_000a, "stopped");
		wait_event(2500);
		check("stopped", 32'(n), 32'h0000_09c4);
		wr(OFS_CONTROL, 16'h0215);
		osc_en <= 4'h0;
		wait_event(2500);
		check("source off", 32'(n), 32'h0000_09c4);
		osc_en <= 4'hf;
		wait_event(3000);
		check("source on", 32'(n inside {[2020:2060]}), 32'h0000_0001);
		wr(OFS_CLOCK_CONTROL, 16'h0102);
		rd(OFS_CLOCK_CONTROL, 32'h0000_0103, "absent source");
		end_of_test();
	end
endmodule
